// file: bench/tb_top.sv
// self-checking testbench for the interrupt priority bank
`timescale 1ns/1ps
`include "ipb_params.svh"
module tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // priority outputs, same order as src_enable from its msb down
  logic [2:0] pr [25];
  logic [24:0] src_enable;
  int fails = 0;
  int total_checks = 0;
  logic [11:0] offs [7] = '{`IPB_OFF_CAN1_SPI2, `IPB_OFF_CAPT_DMA3, `IPB_OFF_CMP_CAPT6,
    `IPB_OFF_TMR6_CMP8, `IPB_OFF_TMR_I2C2, `IPB_OFF_CAN2_EXT, `IPB_OFF_AUD_CAN2};
  logic [15:0] masks [7] = '{16'h7777, 16'h7777, 16'h7777, 16'h7707, 16'h7777, 16'h7777,
    16'h7007};
  int first [7] = '{0, 4, 8, 12, 15, 19, 23};

  ipb_bank ipb_bank_i (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .can1_event_prio(pr[0]), .can1_rx_ready_prio(pr[1]),
    .spi2_event_prio(pr[2]), .spi2_error_prio(pr[3]), .capture5_prio(pr[4]),
    .capture4_prio(pr[5]), .capture3_prio(pr[6]), .dma_ch3_done_prio(pr[7]),
    .compare7_prio(pr[8]), .compare6_prio(pr[9]), .compare5_prio(pr[10]),
    .capture6_prio(pr[11]), .timer6_prio(pr[12]), .dma_ch4_done_prio(pr[13]),
    .compare8_prio(pr[14]), .timer8_prio(pr[15]), .i2c2_master_prio(pr[16]),
    .i2c2_slave_prio(pr[17]), .timer7_prio(pr[18]), .can2_rx_ready_prio(pr[19]),
    .ext_irq4_prio(pr[20]), .ext_irq3_prio(pr[21]), .timer9_prio(pr[22]),
    .audio_if_error_prio(pr[23]), .can2_event_prio(pr[24]), .src_enable(src_enable)
  );

  always #20 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // one apb transfer; request held until pready is sampled high or 50 cycles pass
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d,
    input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'hFFFF, d};
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
    input logic e);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, a, d, s, rd, err);
    chk(err, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp, input logic e);
    logic [31:0] rd;
    logic err;
    xfer(1'b0, a, 16'h0000, 4'h0, rd, err);
    chk(rd, {16'h0000, exp});
    chk(err, e);
  endtask : rd_chk

  // every implemented field of register i against its output and enable bit
  task automatic out_chk(input int i, input logic [15:0] w);
    int k;
    k = first[i];
    for (int f = 3; f >= 0; f--)
      if (masks[i][f*4])
      begin
        chk(pr[k], w[f*4+:3]);
        chk(src_enable[24-k], w[f*4+:3] != 3'h0);
        k++;
      end
  endtask : out_chk

  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
  endtask : do_reset

  task automatic t_reset_state;
    for (int i = 0; i < 7; i++)
    begin
      rd_chk(offs[i], 16'h4444 & masks[i], 1'b0);
      out_chk(i, 16'h4444);
    end
  endtask : t_reset_state

  // every code in every register, with the unused bits written as ones
  task automatic t_codes;
    logic [2:0] c;
    logic [15:0] w;
    for (int v = 0; v < 8; v++)
      for (int i = 0; i < 7; i++)
      begin
        c = v[2:0];
        w = {4{1'b1, c}};
        wr(offs[i], w, 4'hF, 1'b0);
        out_chk(i, w & masks[i]);
        rd_chk(offs[i], w & masks[i], 1'b0);
      end
  endtask : t_codes

  // distinct values per field catch misplaced fields
  task automatic t_fields;
    logic [15:0] pats [2] = '{16'h7531, 16'h0246};
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 7; i++)
      begin
        wr(offs[i], pats[p], 4'hF, 1'b0);
        out_chk(i, pats[p] & masks[i]);
        rd_chk(offs[i], pats[p] & masks[i], 1'b0);
      end
  endtask : t_fields

  task automatic t_strobes;
    wr(offs[4], 16'h7777, 4'hF, 1'b0);
    wr(offs[4], 16'h0000, 4'h2, 1'b0);
    rd_chk(offs[4], 16'h0077, 1'b0);
    out_chk(4, 16'h0077);
    wr(offs[4], 16'h0000, 4'hC, 1'b0);
    rd_chk(offs[4], 16'h0077, 1'b0);
    wr(offs[4], 16'h3333, 4'h1, 1'b0);
    rd_chk(offs[4], 16'h0033, 1'b0);
    out_chk(4, 16'h0033);
  endtask : t_strobes

  task automatic t_unmapped;
    logic [11:0] bad [3] = '{12'h01C, 12'h002, 12'hFFF};
    for (int j = 0; j < 3; j++)
    begin
      wr(bad[j], 16'h0000, 4'hF, 1'b1);
      rd_chk(bad[j], 16'h0000, 1'b1);
    end
    rd_chk(offs[0], 16'h0246, 1'b0);
    out_chk(0, 16'h0246);
  endtask : t_unmapped

  initial
  begin
    do_reset;
    t_reset_state;
    t_codes;
    t_fields;
    t_strobes;
    t_unmapped;
    @(posedge mclk);
    do_reset;
    t_reset_state;
    tally_and_finish;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("BAD %0t: run did not complete", $time);
    tally_and_finish;
  end
endmodule : tb_top

// file: rtl/ipb_bank.sv
// interrupt priority bank with an APB register port
//
// Overview of operation
// - field value is the priority in binary; 111 gives priority seven, highest.
// - field value 001 gives the lowest enabled priority, one.
// - field value 000 disables the source entirely.
// - power-on reset loads 100 into every implemented field.
// - implemented fields are read/write; reads return the last value written.
// - fields sit at bits 14:12, 10:8, 6:4, 2:0; bits 15, 11, 7, 3 unused.
// - unimplemented bits read zero; writes to them do nothing.
// - register fourteen implements only bits 14:12 and 2:0.
// - register eleven low byte implements only bits 2:0.
// - any reset returns every source in the bank to priority four.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ipb_params.svh"
module ipb_bank
  import ipb_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // priorities, register can1_spi2_priority
  output logic [2:0] can1_event_prio,
  output logic [2:0] can1_rx_ready_prio,
  output logic [2:0] spi2_event_prio,
  output logic [2:0] spi2_error_prio,
  // priorities, register capture_dma3_priority
  output logic [2:0] capture5_prio,
  output logic [2:0] capture4_prio,
  output logic [2:0] capture3_prio,
  output logic [2:0] dma_ch3_done_prio,
  // priorities, register compare_capture6_priority
  output logic [2:0] compare7_prio,
  output logic [2:0] compare6_prio,
  output logic [2:0] compare5_prio,
  output logic [2:0] capture6_prio,
  // priorities, register timer6_dma4_compare8_priority
  output logic [2:0] timer6_prio,
  output logic [2:0] dma_ch4_done_prio,
  output logic [2:0] compare8_prio,
  // priorities, register timer_i2c2_priority
  output logic [2:0] timer8_prio,
  output logic [2:0] i2c2_master_prio,
  output logic [2:0] i2c2_slave_prio,
  output logic [2:0] timer7_prio,
  // priorities, register can2rx_extint_timer9_priority
  output logic [2:0] can2_rx_ready_prio,
  output logic [2:0] ext_irq4_prio,
  output logic [2:0] ext_irq3_prio,
  output logic [2:0] timer9_prio,
  // priorities, register audio_err_can2_priority
  output logic [2:0] audio_if_error_prio,
  output logic [2:0] can2_event_prio,
  // per-source enable, high while the field is not zero
  output logic [24:0] src_enable
);

  localparam logic [3:0] REG_MASK [`IPB_NUM_REGS] = '{
    `IPB_MASK_FULL, `IPB_MASK_FULL, `IPB_MASK_FULL, `IPB_MASK_REG11,
    `IPB_MASK_FULL, `IPB_MASK_FULL, `IPB_MASK_REG14
  };

  // widen a field mask to the bits that fields occupy
  function automatic ipb_word_type ipb_expand(input logic [3:0] m);
    ipb_word_type w;
    w = '0;
    for (int i = 0; i < 4; i++)
    begin
      w[i * 4 +: 3] = {3{m[i]}};
    end
    return w;
  endfunction : ipb_expand

  ipb_apb_state_type state;
  logic [2:0] idx_q;
  logic hit_q;
  logic [2:0] next_idx;
  logic next_hit;
  logic commit;
  logic take;
  logic boot_q;
  ipb_word_type rd_bus [`IPB_NUM_REGS];
  ipb_word_type rd_sel;
  ipb_word_type rd_cur;

  // address decode; one aligned word per register
  always_comb
  begin
    next_idx = 3'h0;
    next_hit = 1'b1;
    case (paddr)
      `IPB_OFF_CAN1_SPI2: next_idx = 3'h0;
      `IPB_OFF_CAPT_DMA3: next_idx = 3'h1;
      `IPB_OFF_CMP_CAPT6: next_idx = 3'h2;
      `IPB_OFF_TMR6_CMP8: next_idx = 3'h3;
      `IPB_OFF_TMR_I2C2: next_idx = 3'h4;
      `IPB_OFF_CAN2_EXT: next_idx = 3'h5;
      `IPB_OFF_AUD_CAN2: next_idx = 3'h6;
      default: next_hit = 1'b0;
    endcase
  end

  assign take = (state == IPB_IDLE) && psel && penable;
  // writes land on the edge where the master sees pready
  assign commit = (state == IPB_RESP) && psel && penable && pwrite && hit_q;
  assign rd_sel = rd_bus[next_idx];
  assign rd_cur = rd_bus[idx_q];

  // bus handshake: one wait cycle, then a one-cycle pready
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= IPB_IDLE;
      pready <= 1'b0;
    end
    else
    begin
      case (state)
        IPB_IDLE:
        begin
          if (take)
          begin
            state <= IPB_RESP;
            pready <= 1'b1;
          end
        end
        IPB_RESP:
        begin
          state <= IPB_IDLE;
          pready <= 1'b0;
        end
        default:
        begin
          state <= IPB_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // latch decode and answer
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx_q <= 3'h0;
      hit_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (take)
    begin
      idx_q <= next_idx;
      hit_q <= next_hit;
      pslverr <= !next_hit;
      prdata <= (next_hit && !pwrite) ? {16'h0000, rd_sel} : 32'h0000_0000;
    end
    else
    begin
      pslverr <= 1'b0;
    end
  end

  // marks the first cycle after reset release
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boot_q <= 1'b1;
    end
    else
    begin
      boot_q <= 1'b0;
    end
  end

  genvar r;
  generate
    for (r = 0; r < `IPB_NUM_REGS; r++)
    begin : g_reg
      ipb_reg_if rif();
      assign rif.wr_be = (commit && idx_q == 3'(r)) ? pstrb[1:0] : 2'b00;
      assign rif.wr_data = pwdata[15:0];
      assign rd_bus[r] = rif.rd_data;
      ipb_prio_reg #(
        .IMPL(REG_MASK[r])
      ) u_reg (
        .mclk(mclk),
        .arst_n(arst_n),
        .rif(rif)
      );
    end
  endgenerate

  // field values go straight from the field flops to the priority outputs
  assign can1_event_prio = g_reg[0].rif.prio[3];
  assign can1_rx_ready_prio = g_reg[0].rif.prio[2];
  assign spi2_event_prio = g_reg[0].rif.prio[1];
  assign spi2_error_prio = g_reg[0].rif.prio[0];
  assign capture5_prio = g_reg[1].rif.prio[3];
  assign capture4_prio = g_reg[1].rif.prio[2];
  assign capture3_prio = g_reg[1].rif.prio[1];
  assign dma_ch3_done_prio = g_reg[1].rif.prio[0];
  assign compare7_prio = g_reg[2].rif.prio[3];
  assign compare6_prio = g_reg[2].rif.prio[2];
  assign compare5_prio = g_reg[2].rif.prio[1];
  assign capture6_prio = g_reg[2].rif.prio[0];
  assign timer6_prio = g_reg[3].rif.prio[3];
  assign dma_ch4_done_prio = g_reg[3].rif.prio[2];
  assign compare8_prio = g_reg[3].rif.prio[0];
  assign timer8_prio = g_reg[4].rif.prio[3];
  assign i2c2_master_prio = g_reg[4].rif.prio[2];
  assign i2c2_slave_prio = g_reg[4].rif.prio[1];
  assign timer7_prio = g_reg[4].rif.prio[0];
  assign can2_rx_ready_prio = g_reg[5].rif.prio[3];
  assign ext_irq4_prio = g_reg[5].rif.prio[2];
  assign ext_irq3_prio = g_reg[5].rif.prio[1];
  assign timer9_prio = g_reg[5].rif.prio[0];
  assign audio_if_error_prio = g_reg[6].rif.prio[3];
  assign can2_event_prio = g_reg[6].rif.prio[0];

  // zero-priority sources never request
  assign src_enable = {
    g_reg[0].rif.en,
    g_reg[1].rif.en,
    g_reg[2].rif.en,
    g_reg[3].rif.en[3:2],
    g_reg[3].rif.en[0],
    g_reg[4].rif.en,
    g_reg[5].rif.en,
    g_reg[6].rif.en[3],
    g_reg[6].rif.en[0]
  };

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_max_code: assert property (
    commit && idx_q == 3'h0 && pstrb[1] && pwdata[14:12] == `IPB_PRIO_MAX
    |=> can1_event_prio == `IPB_PRIO_MAX && src_enable[24])
    else $error("code 111 did not give priority seven");

  a_min_code: assert property (
    commit && idx_q == 3'h0 && pstrb[0] && pwdata[2:0] == `IPB_PRIO_MIN
    |=> spi2_error_prio == `IPB_PRIO_MIN && src_enable[21])
    else $error("code 001 did not give priority one");

  a_off_code: assert property (
    commit && idx_q == 3'h5 && pstrb[0] && pwdata[2:0] == `IPB_PRIO_OFF
    |=> timer9_prio == `IPB_PRIO_OFF && !src_enable[2])
    else $error("code 000 did not disable the source");

  a_reset_level: assert property (
    boot_q |-> can1_event_prio == `IPB_PRIO_RST && compare8_prio == `IPB_PRIO_RST
    && can2_event_prio == `IPB_PRIO_RST && src_enable == '1)
    else $error("fields not at priority four after reset");

  a_write_lands: assert property (
    commit && pstrb[1:0] == 2'b11
    |=> rd_cur == ($past(pwdata[15:0]) & ipb_expand(REG_MASK[idx_q])))
    else $error("written value not read back");

  a_read_path: assert property (
    take && !pwrite && next_hit |=> pready && prdata == {16'h0000, $past(rd_sel)})
    else $error("read data does not match register");

  a_gap_bits: assert property (
    (rd_cur & `IPB_GAP_BITS) == 16'h0000)
    else $error("unused bit reads nonzero");

  a_unimpl_zero: assert property (
    (rd_cur & ~ipb_expand(REG_MASK[idx_q])) == 16'h0000)
    else $error("unimplemented bit reads nonzero");

  a_reg14_mask: assert property (
    rd_bus[6][11:3] == 9'h000 && !rd_bus[6][15])
    else $error("register fourteen unimplemented bits nonzero");

  a_reg11_low: assert property (
    rd_bus[3][7:3] == 5'h00)
    else $error("register eleven low byte extra bits nonzero");

  a_prio_track: assert property (
    commit && idx_q == 3'h6 && pstrb[1]
    |=> audio_if_error_prio == $past(pwdata[`IPB_HI_FIELD +: 3])
    && src_enable[1] == (audio_if_error_prio != `IPB_PRIO_OFF))
    else $error("priority output does not follow the field");

  a_pready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_unmapped: assert property (
    take && !next_hit |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not answered with an error");

  a_ready_follows: assert property (
    pready == $past(take))
    else $error("pready not exactly one cycle after the access is taken");

  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("pslverr raised without pready");

  a_upper_zero: assert property (
    prdata[31:16] == 16'h0000)
    else $error("upper read data bits nonzero");

  a_byte0_only: assert property (
    commit && idx_q == 3'h4 && pstrb[1:0] == 2'b01
    |=> timer8_prio == $past(timer8_prio) && timer7_prio == $past(pwdata[2:0]))
    else $error("low byte strobe wrote the wrong lane");

  a_byte1_only: assert property (
    commit && idx_q == 3'h4 && pstrb[1:0] == 2'b10
    |=> timer7_prio == $past(timer7_prio) && timer8_prio == $past(pwdata[14:12]))
    else $error("high byte strobe wrote the wrong lane");

  a_reg11_write: assert property (
    commit && idx_q == 3'h3 && pstrb[0]
    |=> compare8_prio == $past(pwdata[2:0]) && src_enable[10] == (compare8_prio != 3'h0))
    else $error("register eleven low field does not follow the write");

  a_reg14_write: assert property (
    commit && idx_q == 3'h6 && pstrb[0]
    |=> can2_event_prio == $past(pwdata[2:0]) && src_enable[0] == (can2_event_prio != 3'h0))
    else $error("register fourteen low field does not follow the write");

  a_reset_outputs: assert property (
    boot_q |-> capture5_prio == `IPB_PRIO_RST && timer6_prio == `IPB_PRIO_RST
    && timer8_prio == `IPB_PRIO_RST && can2_rx_ready_prio == `IPB_PRIO_RST
    && audio_if_error_prio == `IPB_PRIO_RST && ext_irq3_prio == `IPB_PRIO_RST
    && compare5_prio == `IPB_PRIO_RST && spi2_event_prio == `IPB_PRIO_RST)
    else $error("source not at priority four after reset");

endmodule : ipb_bank

// file: rtl/ipb_params.svh
// constants for the interrupt priority bank
`ifndef IPB_PARAMS_SVH
`define IPB_PARAMS_SVH
`define IPB_NUM_REGS 7
`define IPB_OFF_CAN1_SPI2 12'h000
`define IPB_OFF_CAPT_DMA3 12'h004
`define IPB_OFF_CMP_CAPT6 12'h008
`define IPB_OFF_TMR6_CMP8 12'h00C
`define IPB_OFF_TMR_I2C2 12'h010
`define IPB_OFF_CAN2_EXT 12'h014
`define IPB_OFF_AUD_CAN2 12'h018
`define IPB_PRIO_RST 3'h4
`define IPB_PRIO_OFF 3'h0
`define IPB_PRIO_MIN 3'h1
`define IPB_PRIO_MAX 3'h7
`define IPB_MASK_FULL 4'hF
`define IPB_MASK_REG11 4'hD
`define IPB_MASK_REG14 4'h9
`define IPB_GAP_BITS 16'h8888
`define IPB_HI_FIELD 12
`define IPB_LO_FIELD 0
`endif

// file: rtl/ipb_pkg.sv
// types shared by the interrupt priority bank
package ipb_pkg;
  typedef logic [2:0] ipb_prio_type;
  typedef logic [15:0] ipb_word_type;
  typedef enum logic [0:0] {
    IPB_IDLE = 1'b0,
    IPB_RESP = 1'b1
  } ipb_apb_state_type;
endpackage : ipb_pkg

// file: rtl/ipb_prio_reg.sv
// one 16-bit register of four 3-bit priority fields
`timescale 1ns/1ps
`include "ipb_params.svh"
module ipb_prio_reg
  import ipb_pkg::*;
#(
  parameter logic [3:0] IMPL = `IPB_MASK_FULL
)(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // bank side
  ipb_reg_if.regs rif
);
  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_fld
      if (IMPL[k])
      begin : g_impl
        ipb_prio_type fld;
        logic en;
        always_ff @(posedge mclk or negedge arst_n)
        begin
          if (!arst_n)
          begin
            fld <= `IPB_PRIO_RST;
            en <= 1'b1;
          end
          else if (rif.wr_be[k / 2])
          begin
            fld <= rif.wr_data[k * 4 +: 3];
            en <= |rif.wr_data[k * 4 +: 3];
          end
        end
        assign rif.prio[k] = fld;
        assign rif.en[k] = en;
        assign rif.rd_data[k * 4 +: 4] = {1'b0, fld};
        a_disable_code: assert property (@(posedge mclk) disable iff (!arst_n)
          (fld == `IPB_PRIO_OFF) == !en)
          else $error("priority zero must disable the source");
      end
      else
      begin : g_none
        assign rif.prio[k] = `IPB_PRIO_OFF;
        assign rif.en[k] = 1'b0;
        assign rif.rd_data[k * 4 +: 4] = 4'h0;
      end
    end
  endgenerate
endmodule : ipb_prio_reg

// file: rtl/ipb_reg_if.sv
// link between the bus side and one priority register
`timescale 1ns/1ps
interface ipb_reg_if;
  wire logic [1:0] wr_be;
  wire logic [15:0] wr_data;
  wire logic [15:0] rd_data;
  wire logic [3:0][2:0] prio;
  wire logic [3:0] en;
  modport bank (output wr_be, output wr_data, input rd_data, input prio, input en);
  modport regs (input wr_be, input wr_data, output rd_data, output prio, output en);
endinterface : ipb_reg_if
